// ===== verilog/ccct_defs.svh
// Offsets, field positions, reset values and codes of the channel control block
`ifndef CCCT_DEFS_SVH
`define CCCT_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CCCT_OFF_CTRL2 8'h00
`define CCCT_OFF_LINK 8'h04
`define CCCT_OFF_IRQ_ST 8'h08
`define CCCT_OFF_IRQ_MASK 8'h0c
`define CCCT_OFF_STATE 8'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CCCT_B_FLT_HOLD 15
`define CCCT_B_FLT_LVL 14
`define CCCT_B_FLT_TRI 13
`define CCCT_B_INV 12
`define CCCT_B_FDUTY_HI 10
`define CCCT_B_FDUTY_LO 9
`define CCCT_B_CASC 8
`define CCCT_B_TRIG 7
`define CCCT_B_TSTAT 6
`define CCCT_B_TRIS 5
`define CCCT_B_SEL_HI 4
`define CCCT_B_SEL_LO 0
`define CCCT_CTRL2_WMASK 16'hf7ff
`define CCCT_CTRL2_RST 16'h000c

// ----------------------------------------------------------------
// Link register fields
// ----------------------------------------------------------------
`define CCCT_B_MODE_HI 2
`define CCCT_B_MODE_LO 0
`define CCCT_B_AUTOCLR 3
`define CCCT_B_FLT_EN 4

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define CCCT_IRQ_FAULT0 0
`define CCCT_IRQ_TRIG_SET 1
`define CCCT_IRQ_TRIG_CLR 2

// ----------------------------------------------------------------
// Compare modes and source codes
// ----------------------------------------------------------------
`define CCCT_MODE_EDGE_PWM 3'h6
`define CCCT_MODE_CENTER_PWM 3'h7
`define CCCT_SEL_NONE 5'h00
`define CCCT_SEL_TMR_FIRST 5'h0b
`define CCCT_SEL_TMR_LAST 5'h0d
`define CCCT_SEL_CMP_FIRST 5'h18
`define CCCT_SEL_CMP_LAST 5'h1a
`define CCCT_SEL_EXT_B 5'h1d
`define CCCT_SEL_EXT_A 5'h1e
`define CCCT_SEL_SELF 5'h1f

`endif

// ===== verilog/ccct_pkg.sv
// Types shared by the channel control block
package ccct_pkg;

	typedef enum logic [0:0] {
		CCCT_RUN = 1'b0,
		CCCT_FAULT = 1'b1
	} ccct_flt_t;

	typedef struct packed {
		ccct_flt_t flt;
		logic [15:0] ctrl;
		logic [2:0] mode;
		logic autoclr;
		logic flt_en;
		logic [2:0] irq_st;
		logic [2:0] irq_mask;
		logic src_prev;
		logic pin;
		logic oe;
		logic hold;
		logic sync;
		logic casc;
		logic irq;
		logic wreq;
		logic [31:0] rdata;
	} ccct_state_t;

	typedef struct packed {
		logic [1:0] active;
	} ccct_fduty_state_t;

endpackage

// ===== verilog/ccct_duty_buffer.sv
// Fine duty value buffer: loads at period start in PWM modes, else at once
`timescale 1ns/1ps
`default_nettype none
module ccct_duty_buffer (
	input wire logic clk,
	input wire logic srst,
	input wire logic pwm_mode,
	input wire logic period_start,
	input wire logic [1:0] staged,
	output logic [1:0] active
);
	ccct_pkg::ccct_fduty_state_t s_reg;
	ccct_pkg::ccct_fduty_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (!pwm_mode) begin
			s_next.active = staged;
		end else if (period_start) begin
			s_next.active = staged;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign active = s_reg.active;

	chk_fduty_direct_load: assert property (
		@(posedge clk) disable iff (srst)
		!pwm_mode |=> active == $past(staged))
		else $error("fine duty not applied at once outside PWM");
	chk_fduty_buffered_hold: assert property (
		@(posedge clk) disable iff (srst)
		pwm_mode && !period_start |=> active == $past(active))
		else $error("fine duty changed inside a PWM period");
endmodule
`default_nettype wire

// ===== verilog/ccct_channel_ctrl.sv
// Compare channel second control stage with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "ccct_defs.svh"
module ccct_channel_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic COMPARE_OUT,
	input wire logic FAULT_IN,
	input wire logic PERIOD_START,
	input wire logic TIMER_MATCH_RS,
	input wire logic EXT_TRIG_A,
	input wire logic EXT_TRIG_B,
	input wire logic [2:0] TIMER_EVT,
	input wire logic [2:0] CMP_EVT,
	input wire logic [31:0] OTHER_SRC,
	output logic PIN_OUT,
	output logic PIN_OE,
	output logic [1:0] FINE_DELAY,
	output logic CASCADE_EN,
	output logic TIMER_HOLD_CLEAR,
	output logic SYNC_PULSE,
	output logic IRQ
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 8");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Self code and unused code give no event, so a mis-set channel
	// cannot retrigger itself through this path.
	function automatic logic pick_source(input logic [4:0] sel,
		input logic ea, input logic eb, input logic [2:0] tmr,
		input logic [2:0] cmp, input logic [31:0] other);
		logic [4:0] d;
		d = 5'h00;
		if (sel == `CCCT_SEL_NONE) begin
			return 1'b0;
		end else if (sel == `CCCT_SEL_SELF) begin
			return 1'b0;
		end else if (sel == `CCCT_SEL_EXT_A) begin
			return ea;
		end else if (sel == `CCCT_SEL_EXT_B) begin
			return eb;
		end else if (sel >= `CCCT_SEL_TMR_FIRST
			&& sel <= `CCCT_SEL_TMR_LAST) begin
			d = sel - `CCCT_SEL_TMR_FIRST;
			return tmr[d[1:0]];
		end else if (sel >= `CCCT_SEL_CMP_FIRST
			&& sel <= `CCCT_SEL_CMP_LAST) begin
			d = sel - `CCCT_SEL_CMP_FIRST;
			return cmp[d[1:0]];
		end
		return other[sel];
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam ccct_pkg::ccct_state_t RST_STATE = '{
		flt: ccct_pkg::CCCT_RUN,
		ctrl: `CCCT_CTRL2_RST,
		mode: 3'h0,
		autoclr: 1'b0,
		flt_en: 1'b0,
		irq_st: 3'h0,
		irq_mask: 3'h0,
		src_prev: 1'b0,
		pin: 1'b0,
		oe: 1'b1,
		hold: 1'b0,
		sync: 1'b0,
		casc: 1'b0,
		irq: 1'b0,
		wreq: 1'b1,
		rdata: 32'h0000_0000
	};

	ccct_pkg::ccct_state_t s_reg;
	ccct_pkg::ccct_state_t s_next;
	logic [1:0] fduty_active;
	logic in_pwm;
	logic fault_arm;
	logic acc;
	logic wr;
	logic src_now;
	logic set_evt;
	logic clr_evt;
	logic [7:0] addr8;

	assign addr8 = 8'(AVS_ADDRESS);
	assign in_pwm = s_reg.mode == `CCCT_MODE_EDGE_PWM
		|| s_reg.mode == `CCCT_MODE_CENTER_PWM;
	assign fault_arm = in_pwm && s_reg.flt_en;
	assign acc = (AVS_READ || AVS_WRITE) && !s_reg.wreq;
	assign wr = AVS_WRITE && acc;
	assign src_now = pick_source(
		s_reg.ctrl[`CCCT_B_SEL_HI:`CCCT_B_SEL_LO],
		EXT_TRIG_A, EXT_TRIG_B, TIMER_EVT, CMP_EVT, OTHER_SRC);
	assign set_evt = s_reg.ctrl[`CCCT_B_TRIG] && src_now
		&& !s_reg.src_prev && !s_reg.ctrl[`CCCT_B_TSTAT];
	assign clr_evt = s_reg.ctrl[`CCCT_B_TRIG] && s_reg.autoclr
		&& TIMER_MATCH_RS && s_reg.ctrl[`CCCT_B_TSTAT];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.src_prev = src_now;

		// Bus: one wait state, then the access lands
		if ((AVS_READ || AVS_WRITE) && s_reg.wreq) begin
			s_next.wreq = 1'b0;
			s_next.rdata = 32'h0000_0000;
			if (addr8 == `CCCT_OFF_CTRL2) begin
				s_next.rdata = {16'h0000, s_reg.ctrl};
			end else if (addr8 == `CCCT_OFF_LINK) begin
				s_next.rdata = {27'h0, s_reg.flt_en, s_reg.autoclr,
					s_reg.mode};
			end else if (addr8 == `CCCT_OFF_IRQ_ST) begin
				s_next.rdata = {29'h0, s_reg.irq_st};
			end else if (addr8 == `CCCT_OFF_IRQ_MASK) begin
				s_next.rdata = {29'h0, s_reg.irq_mask};
			end else if (addr8 == `CCCT_OFF_STATE) begin
				s_next.rdata = {28'h0, fduty_active, s_reg.pin,
					s_reg.flt};
			end
		end else begin
			s_next.wreq = 1'b1;
		end

		if (wr) begin
			if (addr8 == `CCCT_OFF_CTRL2) begin
				s_next.ctrl = merge16(s_reg.ctrl, AVS_WRITEDATA,
					AVS_BYTEENABLE) & `CCCT_CTRL2_WMASK;
			end else if (addr8 == `CCCT_OFF_LINK) begin
				if (AVS_BYTEENABLE[0]) begin
					s_next.mode = AVS_WRITEDATA[`CCCT_B_MODE_HI:
						`CCCT_B_MODE_LO];
					s_next.autoclr = AVS_WRITEDATA[`CCCT_B_AUTOCLR];
					s_next.flt_en = AVS_WRITEDATA[`CCCT_B_FLT_EN];
				end
			end else if (addr8 == `CCCT_OFF_IRQ_ST) begin
				if (AVS_BYTEENABLE[0]) begin
					s_next.irq_st = s_reg.irq_st & ~AVS_WRITEDATA[2:0];
				end
			end else if (addr8 == `CCCT_OFF_IRQ_MASK) begin
				if (AVS_BYTEENABLE[0]) begin
					s_next.irq_mask = AVS_WRITEDATA[2:0];
				end
			end
		end

		// Trigger status: auto clear on a timer match, hardware set last
		if (clr_evt) begin
			s_next.ctrl[`CCCT_B_TSTAT] = 1'b0;
		end
		if (set_evt) begin
			s_next.ctrl[`CCCT_B_TSTAT] = 1'b1;
		end

		// Sticky events, set beats a same-cycle clear
		if (fault_arm && FAULT_IN) begin
			s_next.irq_st[`CCCT_IRQ_FAULT0] = 1'b1;
		end
		if (set_evt) begin
			s_next.irq_st[`CCCT_IRQ_TRIG_SET] = 1'b1;
		end
		if (clr_evt && !set_evt) begin
			s_next.irq_st[`CCCT_IRQ_TRIG_CLR] = 1'b1;
		end

		// Fault state machine
		case (s_reg.flt)
			ccct_pkg::CCCT_RUN: begin
				if (fault_arm && FAULT_IN) begin
					s_next.flt = ccct_pkg::CCCT_FAULT;
				end
			end
			ccct_pkg::CCCT_FAULT: begin
				if (!fault_arm) begin
					s_next.flt = ccct_pkg::CCCT_RUN;
				end else if (FAULT_IN) begin
					s_next.flt = ccct_pkg::CCCT_FAULT;
				end else if (s_reg.ctrl[`CCCT_B_FLT_HOLD]) begin
					if (!s_next.irq_st[`CCCT_IRQ_FAULT0]) begin
						s_next.flt = ccct_pkg::CCCT_RUN;
					end
				end else if (PERIOD_START) begin
					s_next.flt = ccct_pkg::CCCT_RUN;
				end
			end
			default: begin
				s_next.flt = ccct_pkg::CCCT_RUN;
			end
		endcase

		// Pin drive; invert covers only the compare path
		if (s_next.flt == ccct_pkg::CCCT_FAULT) begin
			s_next.pin = s_next.ctrl[`CCCT_B_FLT_LVL];
		end else begin
			s_next.pin = COMPARE_OUT ^ s_next.ctrl[`CCCT_B_INV];
		end
		s_next.oe = !s_next.ctrl[`CCCT_B_TRIS];
		if (s_next.flt == ccct_pkg::CCCT_FAULT
			&& s_next.ctrl[`CCCT_B_FLT_TRI]) begin
			s_next.oe = 1'b1;
		end

		s_next.casc = s_next.ctrl[`CCCT_B_CASC];
		s_next.hold = s_next.ctrl[`CCCT_B_TRIG]
			&& !s_next.ctrl[`CCCT_B_TSTAT];
		s_next.sync = !s_reg.ctrl[`CCCT_B_TRIG] && src_now
			&& !s_reg.src_prev;
		s_next.irq = |(s_next.irq_st & s_next.irq_mask);
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			s_reg <= RST_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Fine duty buffer
	// ----------------------------------------------------------------
	// Sub-cycle delay itself is made by the pad delay line from FINE_DELAY.
	ccct_duty_buffer u_fduty (
		.clk(CLK),
		.srst(SRST),
		.pwm_mode(in_pwm),
		.period_start(PERIOD_START),
		.staged(s_reg.ctrl[`CCCT_B_FDUTY_HI:`CCCT_B_FDUTY_LO]),
		.active(fduty_active)
	);

	assign AVS_READDATA = s_reg.rdata;
	assign AVS_WAITREQUEST = s_reg.wreq;
	assign PIN_OUT = s_reg.pin;
	assign PIN_OE = s_reg.oe;
	assign FINE_DELAY = fduty_active;
	assign CASCADE_EN = s_reg.casc;
	assign TIMER_HOLD_CLEAR = s_reg.hold;
	assign SYNC_PULSE = s_reg.sync;
	assign IRQ = s_reg.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_fault_level_out: assert property (
		@(posedge CLK) disable iff (SRST)
		s_reg.flt == ccct_pkg::CCCT_FAULT
		|-> PIN_OUT == s_reg.ctrl[`CCCT_B_FLT_LVL])
		else $error("pin not at fault level during fault");
	chk_invert_path: assert property (@(posedge CLK) disable iff (SRST)
		!$past(SRST) && s_reg.flt == ccct_pkg::CCCT_RUN
		|-> PIN_OUT == ($past(COMPARE_OUT) ^ s_reg.ctrl[`CCCT_B_INV]))
		else $error("pin not compare output xor invert");
	chk_hold_exit: assert property (@(posedge CLK) disable iff (SRST)
		!$past(SRST) && s_reg.flt == ccct_pkg::CCCT_RUN
		&& $past(s_reg.flt) == ccct_pkg::CCCT_FAULT
		&& $past(fault_arm) && $past(s_reg.ctrl[`CCCT_B_FLT_HOLD])
		|-> !s_reg.irq_st[`CCCT_IRQ_FAULT0] && !$past(FAULT_IN))
		else $error("held fault left before status clear");
	chk_period_exit: assert property (@(posedge CLK) disable iff (SRST)
		!$past(SRST) && s_reg.flt == ccct_pkg::CCCT_RUN
		&& $past(s_reg.flt) == ccct_pkg::CCCT_FAULT
		&& $past(fault_arm) && !$past(s_reg.ctrl[`CCCT_B_FLT_HOLD])
		|-> $past(PERIOD_START) && !$past(FAULT_IN))
		else $error("fault left outside a period start");
	chk_pin_direction: assert property (
		@(posedge CLK) disable iff (SRST)
		PIN_OE == (!s_reg.ctrl[`CCCT_B_TRIS]
		|| (s_reg.flt == ccct_pkg::CCCT_FAULT
		&& s_reg.ctrl[`CCCT_B_FLT_TRI])))
		else $error("pin enable wrong");
	chk_fault_pwm_only: assert property (
		@(posedge CLK) disable iff (SRST)
		!fault_arm |=> s_reg.flt == ccct_pkg::CCCT_RUN)
		else $error("fault active outside PWM");
	chk_trig_hold: assert property (@(posedge CLK) disable iff (SRST)
		set_evt |=> s_reg.ctrl[`CCCT_B_TSTAT] && !TIMER_HOLD_CLEAR)
		else $error("trigger did not start timer");
	chk_autoclear: assert property (@(posedge CLK) disable iff (SRST)
		clr_evt && !set_evt |=> !s_reg.ctrl[`CCCT_B_TSTAT]
		&& (TIMER_HOLD_CLEAR || !s_reg.ctrl[`CCCT_B_TRIG]))
		else $error("autoclear missed");
	chk_sync_mode: assert property (@(posedge CLK) disable iff (SRST)
		SYNC_PULSE |-> !$past(s_reg.ctrl[`CCCT_B_TRIG]))
		else $error("sync pulse in trigger mode");
	chk_irq_level: assert property (@(posedge CLK) disable iff (SRST)
		IRQ == |(s_reg.irq_st & s_reg.irq_mask))
		else $error("irq does not follow status and mask");
	chk_bus_wait: assert property (@(posedge CLK) disable iff (SRST)
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus answer late");
endmodule
`default_nettype wire

// ===== tb/ccct_far_model.sv
// Far-side model: compare wave, fault input, period and match events, sources
`timescale 1ns/1ps
`default_nettype none
module ccct_far_model (
	input wire logic clk,
	output logic compare_out,
	output logic fault_in,
	output logic period_start,
	output logic timer_match_rs,
	output logic ext_trig_a,
	output logic ext_trig_b,
	output logic [2:0] timer_evt,
	output logic [2:0] cmp_evt,
	output logic [31:0] other_src
);
	// ----------------------------------------------------------------
	// Source levels, one per selector code
	// ----------------------------------------------------------------
	logic [31:0] src_reg;
	initial begin
		src_reg = 32'h0;
		compare_out = 1'b0;
		fault_in = 1'b0;
		period_start = 1'b0;
		timer_match_rs = 1'b0;
	end
	assign ext_trig_a = src_reg[30];
	assign ext_trig_b = src_reg[29];
	assign timer_evt = src_reg[13:11];
	assign cmp_evt = src_reg[26:24];
	// Code 31 names this channel, so that level is never raised
	assign other_src = {1'b0, src_reg[30:0]};
	task automatic set_src(input logic [4:0] c, input logic v);
		@(posedge clk);
		src_reg[c] <= v;
	endtask
	task automatic drive(input logic f, input logic c);
		@(posedge clk);
		fault_in <= f;
		compare_out <= c;
	endtask
	task automatic period();
		@(posedge clk);
		period_start <= 1'b1;
		@(posedge clk);
		period_start <= 1'b0;
	endtask
	task automatic match();
		@(posedge clk);
		timer_match_rs <= 1'b1;
		@(posedge clk);
		timer_match_rs <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb/ccct_channel_ctrl_tb.sv
// Self-checking bench for the channel second control stage
`timescale 1ns/1ps
`default_nettype none
module ccct_channel_ctrl_tb;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hf;
	logic [31:0] AVS_READDATA, OTHER_SRC, rd;
	logic AVS_WAITREQUEST, COMPARE_OUT, FAULT_IN, PERIOD_START, TMR_RS;
	logic EXT_A, EXT_B, PIN_OUT, PIN_OE, CASCADE_EN, THC, SYNC_PULSE, IRQ;
	logic [2:0] TIMER_EVT, CMP_EVT;
	logic [1:0] FINE_DELAY;
	int err_count = 0;
	int cmp_count = 0;
	logic [4:0] tcodes [10] = '{5'h1d, 5'h0b, 5'h0c, 5'h0d, 5'h18,
		5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h10};
	logic [4:0] scodes [7] = '{5'h00, 5'h1e, 5'h1d, 5'h0b, 5'h0c,
		5'h0d, 5'h01};
	always #50 CLK = ~CLK;
	ccct_far_model far (.clk(CLK), .compare_out(COMPARE_OUT),
		.fault_in(FAULT_IN), .period_start(PERIOD_START),
		.timer_match_rs(TMR_RS), .ext_trig_a(EXT_A), .ext_trig_b(EXT_B),
		.timer_evt(TIMER_EVT), .cmp_evt(CMP_EVT), .other_src(OTHER_SRC));
	ccct_channel_ctrl #(.ADDR_W(8)) uut (.CLK(CLK), .SRST(SRST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARE_OUT(COMPARE_OUT),
		.FAULT_IN(FAULT_IN), .PERIOD_START(PERIOD_START),
		.TIMER_MATCH_RS(TMR_RS), .EXT_TRIG_A(EXT_A), .EXT_TRIG_B(EXT_B),
		.TIMER_EVT(TIMER_EVT), .CMP_EVT(CMP_EVT), .OTHER_SRC(OTHER_SRC),
		.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .FINE_DELAY(FINE_DELAY),
		.CASCADE_EN(CASCADE_EN), .TIMER_HOLD_CLEAR(THC),
		.SYNC_PULSE(SYNC_PULSE), .IRQ(IRQ));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (n >= 20) begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		av(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic wc(input logic [15:0] d);
		av(1'b1, 8'h00, {16'h0, d});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk(8'h00, 32'h000c);
		rchk(8'h04, 32'h0);
		rchk(8'h10, 32'h0);
		chk(32'(PIN_OE), 32'h1);
		av(1'b1, 8'h20, 32'hffff);
		rchk(8'h20, 32'h0);
		// Upper lane only: low byte kept, bit 11 reads zero
		AVS_BYTEENABLE <= 4'h2;
		wc(16'hffff);
		AVS_BYTEENABLE <= 4'hf;
		rchk(8'h00, 32'hf70c);
		wc(16'h000c);
	endtask
	task automatic t_pin();
		far.drive(1'b0, 1'b1);
		cyc(3);
		chk(32'(PIN_OUT), 32'h1);
		wc(16'h100c);
		cyc(3);
		chk(32'(PIN_OUT), 32'h0);
		wc(16'h102c);
		cyc(3);
		chk(32'(PIN_OE), 32'h0);
		wc(16'h090c);
		cyc(3);
		chk(32'(CASCADE_EN), 32'h1);
		rchk(8'h00, 32'h010c);
		wc(16'h000c);
		cyc(3);
		chk(32'(CASCADE_EN), 32'h0);
	endtask
	task automatic t_fault();
		av(1'b1, 8'h04, 32'h16);
		wc(16'he02c);
		far.drive(1'b1, 1'b0);
		cyc(3);
		chk(32'(PIN_OUT), 32'h1);
		chk(32'(PIN_OE), 32'h1);
		far.drive(1'b0, 1'b0);
		cyc(3);
		rchk(8'h10, 32'h3);
		av(1'b1, 8'h08, 32'h1);
		cyc(3);
		chk(32'(PIN_OE), 32'h0);
		wc(16'h002c);
		far.drive(1'b1, 1'b1);
		cyc(3);
		chk(32'(PIN_OE), 32'h0);
		chk(32'(PIN_OUT), 32'h0);
		far.drive(1'b0, 1'b1);
		cyc(3);
		chk(32'(PIN_OUT), 32'h0);
		far.period();
		cyc(3);
		chk(32'(PIN_OUT), 32'h1);
		av(1'b1, 8'h04, 32'h10);
		far.drive(1'b1, 1'b1);
		cyc(3);
		rchk(8'h10, 32'h2);
		far.drive(1'b0, 1'b0);
		av(1'b1, 8'h08, 32'h1);
	endtask
	task automatic t_duty();
		av(1'b1, 8'h04, 32'h0);
		for (int v = 0; v < 4; v++) begin
			wc(16'(v << 9) | 16'h000c);
			cyc(3);
			chk(32'(FINE_DELAY), 32'(v));
		end
		av(1'b1, 8'h04, 32'h7);
		wc(16'h020c);
		cyc(3);
		chk(32'(FINE_DELAY), 32'h3);
		far.period();
		cyc(3);
		rchk(8'h10, 32'h4);
		av(1'b1, 8'h04, 32'h0);
	endtask
	task automatic t_trig();
		av(1'b1, 8'h04, 32'h8);
		av(1'b1, 8'h0c, 32'h2);
		wc(16'h009e);
		cyc(2);
		chk(32'(THC), 32'h1);
		far.set_src(5'h1e, 1'b1);
		cyc(3);
		rchk(8'h00, 32'h00de);
		chk(32'(THC), 32'h0);
		chk(32'(IRQ), 32'h1);
		av(1'b1, 8'h0c, 32'h0);
		cyc(2);
		chk(32'(IRQ), 32'h0);
		far.match();
		cyc(3);
		rchk(8'h00, 32'h009e);
		rchk(8'h08, 32'h6);
		av(1'b1, 8'h08, 32'h6);
		rchk(8'h08, 32'h0);
		far.set_src(5'h1e, 1'b0);
		av(1'b1, 8'h04, 32'h0);
		// Converter, comparator and capture codes serve as triggers as well
		foreach (tcodes[i]) begin
			wc({8'h0, 3'h4, tcodes[i]});
			far.set_src(tcodes[i], 1'b1);
			cyc(3);
			rchk(8'h00, {24'h0, 3'h6, tcodes[i]});
			far.set_src(tcodes[i], 1'b0);
		end
		// Autoclear mode off: a match leaves the status set
		far.match();
		cyc(2);
		rchk(8'h00, 32'h00d0);
	endtask
	task automatic t_sync();
		int n;
		foreach (scodes[i]) begin
			wc({11'h0, scodes[i]});
			far.set_src(scodes[i], 1'b1);
			n = 0;
			repeat (6) begin
				@(posedge CLK);
				if (SYNC_PULSE === 1'b1)
					n++;
			end
			chk(32'(n), 32'(scodes[i] != 5'h00));
			chk(32'(THC), 32'h0);
			far.set_src(scodes[i], 1'b0);
			cyc(2);
		end
	endtask
	initial begin
		cyc(8);
		SRST <= 1'b0;
		t_reset();
		t_pin();
		t_fault();
		t_duty();
		t_trig();
		t_sync();
		print_verdict();
	end
endmodule
`default_nettype wire
